// ---- src/matrix_zero_defs.vh ----
`ifndef MATRIX_ZERO_DEFS_VH
`define MATRIX_ZERO_DEFS_VH

// Matrix geometry
`define MZ_NUM_SRC        64
`define MZ_NUM_OUT        95
`define MZ_FIELD_W        6

// Source codes
`define MZ_SRC_LOW        6'h00
`define MZ_SRC_TWO_LO     1
`define MZ_SRC_THREE_LO   5
`define MZ_SRC_FOUR       13
`define MZ_SRC_FLOP_LO    14
`define MZ_SRC_PIPE_LO    20
`define MZ_SRC_EDGE       22
`define MZ_SRC_INV        23
`define MZ_SRC_PIN_LO     24
`define MZ_SRC_CMP_LO     33
`define MZ_SRC_CNT_LO     36
`define MZ_SRC_BANDGAP    41
`define MZ_SRC_PWR_DET    42
`define MZ_SRC_CONV_IRQ   43
`define MZ_SRC_SER_IRQ    44
`define MZ_SRC_UNUSED_A   45
`define MZ_SRC_UNUSED_B   46
`define MZ_SRC_UNUSED_C   47
`define MZ_SRC_OSC_RING   48
`define MZ_SRC_OSC_RC     49
`define MZ_SRC_OSC_LOW    50
`define MZ_SRC_UNUSED_D   51
`define MZ_SRC_CROSS_LO   52
`define MZ_SRC_MTX_RST    62
`define MZ_SRC_HIGH       63

// Register map (byte addresses)
`define MZ_SEL_BASE       12'h000
`define MZ_SEL_LAST       12'h178
`define MZ_CTRL_ADDR      12'h200
`define MZ_STAT_ADDR      12'h204
`define MZ_LOCK_BIT       0

// Reset values
`define MZ_SEL_RESET      6'h00
`define MZ_LOCK_RESET     1'b0

`endif

// ---- src/connection_matrix_zero_router.v ----
// Notes on behaviour
// - Field is binary index; unused codes low, 63 high
// - Output k uses field bits 6k+5 to 6k
// - Outputs 0-7 feed two-input tables; codes 1-4
// - Outputs 8-31 feed three-input tables; codes 5-12
// - Outputs 32-35 feed four-input table; code 13
// - Outputs 36,37 drive flop 0; flops codes 14-19
// - Pipe taps 20,21; edge delay 22; inverter 23
// - Ring, RC, low oscillators at codes 48-50
// - Cross lines 0-9 at codes 52-61
// - Sixty-four sources, ninety-five selector outputs
// - Fields writable until the lock bit is set, then static routing
`include "matrix_zero_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module connection_matrix_zero_router
(
	input  wire        clk_sys_i,
	input  wire        rstn_i,
	// AHB-Lite slave
	input  wire        hsel_i,
	input  wire [31:0] haddr_i,
	input  wire [1:0]  htrans_i,
	input  wire        hwrite_i,
	input  wire [2:0]  hsize_i,
	input  wire [31:0] hwdata_i,
	input  wire        hready_i,
	output reg         hreadyout_o,
	output reg         hresp_o,
	output reg  [31:0] hrdata_o,
	// Sources from logic on this clock
	input  wire [3:0]  two_input_table_result_i,
	input  wire [7:0]  three_input_table_result_i,
	input  wire        four_input_table_result_i,
	input  wire [5:0]  flop_latch_result_i,
	input  wire [1:0]  pipe_delay_tap_i,
	input  wire        edge_delay_result_i,
	input  wire        inverter_result_i,
	input  wire [4:0]  delay_counter_result_i,
	input  wire        converter_irq_i,
	input  wire        serial_irq_i,
	input  wire [9:0]  cross_in_i,
	input  wire        matrix_reset_low_i,
	// Sources from outside this clock domain
	input  wire [8:0]  pin_input_i,
	input  wire [2:0]  comparator_i,
	input  wire        bandgap_good_i,
	input  wire        power_detect_i,
	input  wire        osc_ring_i,
	input  wire        osc_rc_i,
	input  wire        osc_low_i,
	// Selector outputs and lock status
	output reg  [7:0]  two_input_table_in_o,
	output reg  [23:0] three_input_table_in_o,
	output reg  [3:0]  four_input_table_in_o,
	output reg         flop_latch_0_set_reset_low_o,
	output reg         flop_latch_0_data_o,
	output reg  [56:0] upper_route_o,
	output reg         locked_o
);

	// Asynchronous inputs: 17 bits, two flops each
	localparam ASYNC_W = 17;

	wire [ASYNC_W-1:0] async_raw;       // Raw asynchronous sources
	reg  [ASYNC_W-1:0] async_meta_reg;  // First stage, read only by second
	reg  [ASYNC_W-1:0] async_sync_reg;  // Second stage, safe to use

	// Select fields, one per output
	reg  [`MZ_FIELD_W-1:0] sel_mem [0:`MZ_NUM_OUT-1];
	reg                    lock_reg;     // Routing frozen once set

	// Bus data-phase capture
	reg                    wr_pend_reg;  // Write data expected
	reg  [11:0]            wr_addr_reg;  // Latched write address

	wire [`MZ_NUM_SRC-1:0] src;          // The 64 matrix inputs
	wire [`MZ_NUM_OUT-1:0] route;        // Selected values
	wire [`MZ_NUM_OUT*`MZ_FIELD_W-1:0] sel_flat; // Packed fields

	wire        addr_phase;
	wire [11:0] a_addr;
	wire        a_in_sel;
	wire [6:0]  a_index;
	wire        w_in_sel;
	wire [6:0]  w_index;
	wire        fwd_sel;    // Pending field write hits the address read
	wire        fwd_lock;   // Pending lock write not yet stored
	wire        lock_view;  // Lock as a read in this cycle must see it

	assign async_raw = {osc_low_i, osc_rc_i, osc_ring_i, power_detect_i,
		bandgap_good_i, comparator_i, pin_input_i};

	// Two-flop synchroniser for pins, analog and oscillator signals
	always @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			async_meta_reg <= 17'h0_0000;
			async_sync_reg <= 17'h0_0000;
		end
		else
		begin
			async_meta_reg <= async_raw;
			async_sync_reg <= async_meta_reg;
		end
	end

	// Source vector in code order
	assign src[0]      = 1'b0;
	assign src[4:1]    = two_input_table_result_i;
	assign src[12:5]   = three_input_table_result_i;
	assign src[13]     = four_input_table_result_i;
	assign src[19:14]  = flop_latch_result_i;
	assign src[21:20]  = pipe_delay_tap_i;
	assign src[22]     = edge_delay_result_i;
	assign src[23]     = inverter_result_i;
	assign src[32:24]  = async_sync_reg[8:0];
	assign src[35:33]  = async_sync_reg[11:9];
	assign src[40:36]  = delay_counter_result_i;
	assign src[41]     = async_sync_reg[12];
	assign src[42]     = async_sync_reg[13];
	assign src[43]     = converter_irq_i;
	assign src[44]     = serial_irq_i;
	assign src[47:45]  = 3'h0;
	// Oscillators are free-running, so only the synchronised copy is read
	assign src[48]     = async_sync_reg[14];
	assign src[49]     = async_sync_reg[15];
	assign src[50]     = async_sync_reg[16];
	assign src[51]     = 1'b0;
	assign src[61:52]  = cross_in_i;
	assign src[62]     = matrix_reset_low_i;
	assign src[63]     = 1'b1;

	// One 64-to-1 selector per output, field k at bits 6k+5..6k
	genvar k;
	generate
		for (k = 0; k < `MZ_NUM_OUT; k = k + 1)
		begin : g_sel
			assign sel_flat[k*`MZ_FIELD_W +: `MZ_FIELD_W] = sel_mem[k];
			assign route[k] = src[sel_flat[k*`MZ_FIELD_W +: `MZ_FIELD_W]];
		end
	endgenerate

	// Registered outputs, grouped by destination cell
	always @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			two_input_table_in_o         <= 8'h00;
			three_input_table_in_o       <= 24'h00_0000;
			four_input_table_in_o        <= 4'h0;
			flop_latch_0_set_reset_low_o <= 1'b0;
			flop_latch_0_data_o          <= 1'b0;
			upper_route_o                <= 57'h0;
		end
		else
		begin
			two_input_table_in_o         <= route[7:0];
			three_input_table_in_o       <= route[31:8];
			four_input_table_in_o        <= route[35:32];
			flop_latch_0_set_reset_low_o <= route[36];
			flop_latch_0_data_o          <= route[37];
			upper_route_o                <= route[94:38];
		end
	end

	// Address decode for the bus
	assign addr_phase = hsel_i & htrans_i[1] & hready_i;
	assign a_addr     = haddr_i[11:0];
	assign a_in_sel   = (a_addr <= `MZ_SEL_LAST) & (a_addr[1:0] == 2'b00);
	assign a_index    = a_addr[8:2];
	assign w_in_sel   = (wr_addr_reg <= `MZ_SEL_LAST) & (wr_addr_reg[1:0] == 2'b00);
	assign w_index    = wr_addr_reg[8:2];
	// Back-to-back write then read: forward the data not yet stored
	assign fwd_sel    = wr_pend_reg & ~lock_reg & w_in_sel & (w_index == a_index);
	assign fwd_lock   = wr_pend_reg & ~lock_reg & (wr_addr_reg == `MZ_CTRL_ADDR);
	assign lock_view  = fwd_lock ? hwdata_i[`MZ_LOCK_BIT] : lock_reg;

	// Write path: address latched, data taken next cycle
	integer i;
	always @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 12'h000;
			lock_reg    <= `MZ_LOCK_RESET;
			for (i = 0; i < `MZ_NUM_OUT; i = i + 1)
				sel_mem[i] <= `MZ_SEL_RESET;
		end
		else
		begin
			if (hready_i)
			begin
				wr_pend_reg <= addr_phase & hwrite_i;
				wr_addr_reg <= a_addr;
			end
			// Writes after lock are dropped; routing stays fixed
			if (wr_pend_reg && !lock_reg)
			begin
				if (w_in_sel)
					sel_mem[w_index] <= hwdata_i[5:0];
				else if (wr_addr_reg == `MZ_CTRL_ADDR)
					lock_reg <= hwdata_i[`MZ_LOCK_BIT];
			end
		end
	end

	// Read path: zero wait, data registered for the data phase
	always @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			hrdata_o    <= 32'h0000_0000;
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
			locked_o    <= 1'b0;
		end
		else
		begin
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
			locked_o    <= lock_reg;
			if (addr_phase && !hwrite_i)
			begin
				// A write still in its data phase is newer than the store
				if (a_in_sel && fwd_sel)
					hrdata_o <= {26'h0, hwdata_i[5:0]};
				else if (a_in_sel)
					hrdata_o <= {26'h0, sel_mem[a_index]};
				else if (a_addr == `MZ_CTRL_ADDR || a_addr == `MZ_STAT_ADDR)
					hrdata_o <= {31'h0, lock_view};
				else
					hrdata_o <= 32'h0000_0000;     // Unmapped reads zero
			end
		end
	end

endmodule

`default_nettype wire

// ---- src/unused_placeholder_check.v ----
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- sim/matrix_zero_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module matrix_zero_asserts
(
	input wire logic        clk_sys_i,
	input wire logic        rstn_i,
	input wire logic        hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0]  htrans_i,
	input wire logic        hwrite_i,
	input wire logic [31:0] hwdata_i,
	input wire logic        hready_i,
	input wire logic        hreadyout_o,
	input wire logic        hresp_o,
	input wire logic [31:0] hrdata_o,
	input wire logic [3:0]  two_input_table_result_i,
	input wire logic [7:0]  two_input_table_in_o,
	input wire logic        locked_o
);
	// Data-phase flags and a shadow of field 0
	logic       wr0, wrc, rds, rdx;
	logic [5:0] f0;
	wire logic  ap = hsel_i & htrans_i[1] & hready_i;
	// Shadow ignores writes once locked_o is high, one cycle after the block stops taking them
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			{wr0, wrc, rds, rdx} <= 4'h0;
			f0 <= 6'h00;
		end
		else
		begin
			wr0 <= ap & hwrite_i & (haddr_i == 32'h0000_0000);
			wrc <= ap & hwrite_i & (haddr_i == 32'h0000_0200);
			rds <= ap & !hwrite_i & (haddr_i == 32'h0000_0204);
			rdx <= ap & !hwrite_i & (haddr_i == 32'h0000_0180);
			if (wr0 && !locked_o)
				f0 <= hwdata_i[5:0];
		end
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);
	bus_okay_a: assert property (hreadyout_o && !hresp_o)
		else $error("bus stalled or error response");
	lock_holds_a: assert property (locked_o |=> locked_o)
		else $error("lock dropped");
	lock_set_a: assert property (wrc && hwdata_i[0] |-> ##2 locked_o)
		else $error("lock write not taken");
	stat_read_a: assert property (rds |-> hrdata_o[31:1] == 31'h0 ##1
		locked_o == $past(hrdata_o[0]))
		else $error("status read wrong");
	hole_zero_a: assert property (rdx |-> hrdata_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	code_high_a: assert property (f0 == 6'h3f |=> two_input_table_in_o[0])
		else $error("code 63 not high");
	code_low_a: assert property (f0 == 6'h00 |=> !two_input_table_in_o[0])
		else $error("code 0 not low");
	table_route_a: assert property (f0 == 6'h01 |=>
		two_input_table_in_o[0] == $past(two_input_table_result_i[0]))
		else $error("code 1 not routed");
	reset_clear_a: assert property ($rose(rstn_i) |-> !locked_o)
		else $error("lock set after reset");
endmodule
bind connection_matrix_zero_router matrix_zero_asserts u_chk(.clk_sys_i,
	.rstn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i,
	.hreadyout_o, .hresp_o, .hrdata_o, .two_input_table_result_i,
	.two_input_table_in_o, .locked_o);
`default_nettype wire

// ---- sim/macrocell_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Source cells on this clock; bit n feeds matrix code n
module macrocell_model
(
	input wire logic        clk_sys_i,
	input wire logic [63:0] pat_i,
	output logic     [63:0] src_o
);
	// Constant codes see the inverse, so a leak would show
	localparam logic [63:0] KMASK = 64'h8008_E000_0000_0001;
	// Cell outputs are registered, one edge behind the request
	always_ff @(posedge clk_sys_i)
		src_o <= pat_i ^ KMASK;
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk_sys_i = 1'b0;
	logic        rstn_i    = 1'b0;
	logic        hsel      = 1'b0;
	logic        hwrite    = 1'b0;
	logic        e;
	logic [1:0]  htrans    = 2'b00;
	logic [31:0] haddr     = 32'h0000_0000;
	logic [31:0] hwdata    = 32'h0000_0000;
	logic [31:0] rd;
	logic [63:0] pat       = 64'h0000_0000_0000_0000;
	wire logic [63:0] s;
	wire logic [94:0] route;
	wire logic [31:0] hrdata;
	wire logic        rdy;
	wire logic        locked;
	int          err_count = 0;
	int          n_tests   = 0;
	always #5 clk_sys_i = ~clk_sys_i;
	macrocell_model pm(.clk_sys_i, .pat_i(pat), .src_o(s));
	connection_matrix_zero_router uut(.clk_sys_i, .rstn_i, .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(rdy),
		.hreadyout_o(rdy), .hresp_o(), .hrdata_o(hrdata),
		.two_input_table_result_i(s[4:1]), .three_input_table_result_i(s[12:5]),
		.four_input_table_result_i(s[13]), .flop_latch_result_i(s[19:14]),
		.pipe_delay_tap_i(s[21:20]), .edge_delay_result_i(s[22]),
		.inverter_result_i(s[23]), .pin_input_i(s[32:24]),
		.comparator_i(s[35:33]), .delay_counter_result_i(s[40:36]),
		.bandgap_good_i(s[41]), .power_detect_i(s[42]),
		.converter_irq_i(s[43]), .serial_irq_i(s[44]), .osc_ring_i(s[48]),
		.osc_rc_i(s[49]), .osc_low_i(s[50]), .cross_in_i(s[61:52]),
		.matrix_reset_low_i(s[62]), .two_input_table_in_o(route[7:0]),
		.three_input_table_in_o(route[31:8]),
		.four_input_table_in_o(route[35:32]),
		.flop_latch_0_set_reset_low_o(route[36]),
		.flop_latch_0_data_o(route[37]), .upper_route_o(route[94:38]),
		.locked_o(locked));
	// Compare and count; any unknown bit counts as a miss
	task automatic chk(input logic [94:0] got, input logic [94:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One single AHB transfer; read data lands in rd
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk_sys_i); while (rdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk_sys_i); while (rdy !== 1'b1);
		rd = hrdata;
	endtask
	// Covers the four-edge path of synchronised sources
	task automatic wt;
		repeat (6) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic close_out;
		$display("Checks %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		#200_000;
		err_count++;
		close_out;
	end
	initial
	begin
		repeat (10) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		wt;
		chk(route, 95'h0);
		for (int k = 0; k < 95; k++)
		begin
			xfer(1'b1, 32'(k * 4), 32'h0000_003f);
			wt;
			chk(route, 95'h1 << k);
			xfer(1'b0, 32'(k * 4), 32'h0000_0000);
			chk(95'(rd), 95'h3f);
			xfer(1'b1, 32'(k * 4), 32'h0000_0000);
		end
		for (int c = 0; c < 64; c++)
		begin
			xfer(1'b1, 32'h0000_0000, 32'(c));
			for (int b = 0; b < 2; b++)
			begin
				@(posedge clk_sys_i);
				pat <= b[0] ? 64'h1 << c : ~(64'h1 << c);
				e = (c == 63) | (b[0] & !(c == 0 || c == 51 || (c > 44 && c < 48)));
				wt;
				chk(95'(route[0]), 95'(e));
			end
		end
		xfer(1'b1, 32'h0000_0200, 32'h0000_0001);
		xfer(1'b0, 32'h0000_0204, 32'h0000_0000);
		chk(95'(rd), 95'h1);
		chk(95'(locked), 95'h1);
		xfer(1'b1, 32'h0000_0000, 32'h0000_0005);
		xfer(1'b0, 32'h0000_0000, 32'h0000_0000);
		chk(95'(rd), 95'h3f);
		xfer(1'b0, 32'h0000_0180, 32'h0000_0000);
		chk(95'(rd), 95'h0);
		// Reset in mid-run must clear the lock and every field
		@(posedge clk_sys_i);
		rstn_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		wt;
		chk(route, 95'h0);
		chk(95'(locked), 95'h0);
		xfer(1'b1, 32'h0000_0000, 32'h0000_003f);
		wt;
		chk(route, 95'h1);
		close_out;
	end
endmodule
`default_nettype wire
